// >>> design/alarm_defines.svh
/*
  Offsets, field positions, reset values and codes for the alarm reaction block.
  Assumes a 32-bit APB slave and byte addresses on word boundaries.
*/
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R01] brake fault on command versus feedback mismatch
// [R02] selector codes: ignore,warn,disable,fast,stop,torque
// [R03] warning only flags, drive state untouched
// [R04] disable turns drive off at once
// [R05] fast stop ramps, then disables drive
// [R06] normal stop ramps, then disables drive
// [R07] torque limit stop brakes, disables at standstill
// [R08] three independent selectors, all six codes accepted
// [R09] relay enable opens drive-ok relay while active; code keeps it closed for an alarm set to ignore
// [R10] motor overload when motor accumulator full
// [R11] drive overload when drive accumulator full
// [R12] latch off: restart on empty, output low
// [R13] latch on: operator reset needed, output low
// [R14] reaction next cycle, held until restart condition
//////////////////////////////////////////////////////////////////////////////
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// register byte offsets
`define CTRL_OFF    8'h00
`define STATUS_OFF  8'h04
`define MASK_OFF    8'h08
`define STATE_OFF   8'h0C

// control register fields
`define SEL_LSB     0
`define RELAY_LSB   9
`define HOLD_BIT    12
`define CTRL_RST    32'h0000_0000

// reaction selector codes
`define RX_IGNORE   3'h0
`define RX_WARN     3'h1
`define RX_DISABLE  3'h2
`define RX_FAST     3'h3
`define RX_STOP     3'h4
`define RX_TLIM     3'h5

// heat accumulator full scale and empty level
`define HEAT_FULL   16'hFFFF
`define HEAT_EMPTY  16'h0000

`endif

// >>> design/alarm_pkg.sv
/*
  Types for the alarm reaction block: bus carriers, drive command and state.
  Assumes the constants header supplies all numbers.
*/
`default_nettype none
package alarm_pkg;

  // apb request from the master
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // command to the drive core
  typedef struct packed {
    logic enable;
    logic fast_stop;
    logic normal_stop;
    logic tlim_stop;
  } drive_cmd_t;

  // reaction sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_FAST,
    ST_NORM,
    ST_TLIM,
    ST_OFF
  } drive_state_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0]      sync1;      // pin first stage
    logic [2:0]      sync2;      // pin second stage
    logic [2:0][2:0] sel;        // reaction selector per alarm
    logic [2:0]      relay_en;   // relay open enable per alarm
    logic            hold;       // motor overload restart hold
    logic [2:0]      status;     // sticky alarm events
    logic [2:0]      mask;       // interrupt mask
    logic [2:0]      active;     // alarm in force
    logic            rst_seen;   // operator reset taken
    drive_state_t    st;         // reaction sequencer
    apb_rsp_t        rsp;        // bus answer
    drive_cmd_t      cmd;        // drive command
    logic            warn;       // alarm flagged
    logic            relay_ok;   // drive-ok relay closed
    logic            mo_out;     // motor overload output
    logic            irq;        // interrupt line
  } state_t;

endpackage
`default_nettype wire

// >>> design/alarm_reaction.sv
/*
  Alarm reaction logic for brake fault, motor overload and drive overload.
  Assumes brake command, accumulators, ramp-done and standstill come from
  logic on REF_CLK; brake feedback and both reset requests come from pins.
*/
// Local design decisions: the address map and the APB register port.
`include "alarm_defines.svh"
`default_nettype none
module alarm_reaction (
  // clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 SYS_RST,
  // register bus
  input  wire alarm_pkg::apb_req_t  APB_REQ,
  output var  alarm_pkg::apb_rsp_t  APB_RSP,
  // brake command and feedback
  input  wire logic                 BRAKE_CMD,
  input  wire logic                 BRAKE_FB,
  // operator alarm reset
  input  wire logic                 KEYPAD_RST,
  input  wire logic                 DIN_ALARM_RST,
  // heat accumulators
  input  wire logic [15:0]          MOTOR_HEAT,
  input  wire logic [15:0]          DRIVE_HEAT,
  // drive core status
  input  wire logic                 FAST_RAMP_DONE,
  input  wire logic                 NORMAL_RAMP_DONE,
  input  wire logic                 STANDSTILL,
  // drive command and indications
  output var  alarm_pkg::drive_cmd_t DRIVE_CMD,
  output var  logic                 ALARM_WARNING,
  output var  logic                 DRIVE_OK_RELAY,
  output var  logic                 MOTOR_OVERLOAD_OUT,
  output var  logic                 IRQ
);
  import alarm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state and decode signals

  state_t     s_r;          // registered state
  state_t     s_nxt;        // next state
  logic [2:0] is_ign;       // selector asks to ignore
  logic [2:0] is_dis;       // selector asks immediate disable
  logic [2:0] is_fast;      // selector asks fast ramp
  logic [2:0] is_norm;      // selector asks normal ramp
  logic [2:0] is_tlim;      // selector asks torque limit stop

  //////////////////////////////////////////////////////////////////////////
  // per-alarm selector decode, same for all three alarms

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_dec
      // codes 6 and 7 fall to disable, the safe side
      assign is_ign[g]  = (s_r.sel[g] == `RX_IGNORE);                 // R02 R08
      assign is_dis[g]  = (s_r.sel[g] == `RX_DISABLE) ||
                          (s_r.sel[g] > `RX_TLIM);                    // R04
      assign is_fast[g] = (s_r.sel[g] == `RX_FAST);                   // R05
      assign is_norm[g] = (s_r.sel[g] == `RX_STOP);                   // R06
      assign is_tlim[g] = (s_r.sel[g] == `RX_TLIM);                   // R07
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic [2:0]  raw;       // alarm condition this cycle
    logic [2:0]  clr;       // restart condition per alarm
    logic [2:0]  act;       // next active alarms
    logic [2:0]  eff;       // active and not ignored
    logic [2:0]  ev;        // new alarm events
    logic [2:0]  w1c;       // status bits written with one
    logic        rst_req;   // operator reset level
    logic        acc;       // access phase
    logic        done;      // transfer completes at this edge
    logic        any_dis;   // some alarm wants disable
    logic        any_fast;  // some alarm wants fast ramp
    logic        any_norm;  // some alarm wants normal ramp
    logic        any_tlim;  // some alarm wants torque stop
    raw      = 3'h0;
    clr      = 3'h0;
    act      = 3'h0;
    eff      = 3'h0;
    ev       = 3'h0;
    w1c      = 3'h0;
    rst_req  = 1'b0;
    acc      = 1'b0;
    done     = 1'b0;
    any_dis  = 1'b0;
    any_fast = 1'b0;
    any_norm = 1'b0;
    any_tlim = 1'b0;
    s_nxt    = s_r;

    // pins pass two flops before use
    s_nxt.sync1 = {DIN_ALARM_RST, KEYPAD_RST, BRAKE_FB};
    s_nxt.sync2 = s_r.sync1;
    rst_req     = s_r.sync2[1] | s_r.sync2[2];

    // alarm conditions
    raw[0] = BRAKE_CMD ^ s_r.sync2[0];                                // R01
    raw[1] = (MOTOR_HEAT >= `HEAT_FULL);                              // R10
    raw[2] = (DRIVE_HEAT >= `HEAT_FULL);                              // R11

    // operator reset only counts while the latched alarm stands
    if (s_r.active[1] && s_r.hold && rst_req) begin
      s_nxt.rst_seen = 1'b1;                                          // R13
    end

    // restart conditions
    clr[0] = ~raw[0];
    clr[1] = (MOTOR_HEAT == `HEAT_EMPTY) &&
             (~s_r.hold || s_r.rst_seen || rst_req);                  // R12 R13
    clr[2] = (DRIVE_HEAT == `HEAT_EMPTY);

    // alarm stays in force until its restart condition
    act = raw | (s_r.active & ~clr);                                  // R14
    s_nxt.active = act;
    if (~act[1]) begin
      s_nxt.rst_seen = 1'b0;
    end
    eff = act & ~is_ign;                                              // R03
    ev  = raw & ~s_r.active & ~is_ign;

    //----------------------------------------------------------------------
    // apb slave: one wait state, answer registered
    acc  = APB_REQ.psel & APB_REQ.penable;
    done = acc & s_r.rsp.pready;
    s_nxt.rsp.pready  = acc & ~s_r.rsp.pready;
    s_nxt.rsp.pslverr = 1'b0;
    if (acc && !s_r.rsp.pready) begin
      // read data and error prepared for the ready cycle
      s_nxt.rsp.prdata = 32'h0000_0000;
      case (APB_REQ.paddr)
        `CTRL_OFF: begin
          s_nxt.rsp.prdata[12:0] = {s_r.hold, s_r.relay_en, s_r.sel};
        end
        `STATUS_OFF: begin
          s_nxt.rsp.prdata[2:0] = s_r.status;
        end
        `MASK_OFF: begin
          s_nxt.rsp.prdata[2:0] = s_r.mask;
        end
        `STATE_OFF: begin
          // bit 7 is spare and reads zero
          s_nxt.rsp.prdata[10:0] = {s_r.st, 1'b0, s_r.mo_out,
                                    s_r.active & ~is_ign, s_r.active};
        end
        default: begin
          s_nxt.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // writes land only on the edge that sees pready high
    if (done && APB_REQ.pwrite) begin
      case (APB_REQ.paddr)
        `CTRL_OFF: begin
          s_nxt.sel      = APB_REQ.pwdata[`SEL_LSB +: 9];             // R08
          s_nxt.relay_en = APB_REQ.pwdata[`RELAY_LSB +: 3];
          s_nxt.hold     = APB_REQ.pwdata[`HOLD_BIT];
        end
        `STATUS_OFF: begin
          w1c = APB_REQ.pwdata[2:0];
        end
        `MASK_OFF: begin
          s_nxt.mask = APB_REQ.pwdata[2:0];
        end
        default: begin
          // read-only or unmapped: write dropped
        end
      endcase
    end

    //----------------------------------------------------------------------
    // sticky status: a new event beats a same-cycle clear
    s_nxt.status = (s_r.status & ~w1c) | ev;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);

    //----------------------------------------------------------------------
    // reaction sequencer, driven from next active set
    any_dis  = |(eff & is_dis);
    any_fast = |(eff & is_fast);
    any_norm = |(eff & is_norm);
    any_tlim = |(eff & is_tlim);
    case (s_r.st)
      ST_RUN: begin
        // reaction starts on the edge that latches the alarm
        if (any_dis) begin
          s_nxt.st = ST_OFF;                                          // R04 R14
        end else if (any_fast) begin
          s_nxt.st = ST_FAST;                                         // R05
        end else if (any_tlim) begin
          s_nxt.st = ST_TLIM;                                         // R07
        end else if (any_norm) begin
          s_nxt.st = ST_NORM;                                         // R06
        end
      end
      ST_FAST: begin
        // disable when the fast ramp is done or a disable alarm appears
        if (any_dis || FAST_RAMP_DONE) begin
          s_nxt.st = ST_OFF;                                          // R05
        end
      end
      ST_NORM: begin
        // a harsher reaction may take over a normal ramp
        if (any_dis || NORMAL_RAMP_DONE) begin
          s_nxt.st = ST_OFF;                                          // R06
        end else if (any_fast) begin
          s_nxt.st = ST_FAST;
        end else if (any_tlim) begin
          s_nxt.st = ST_TLIM;
        end
      end
      ST_TLIM: begin
        // torque-limited braking ends at standstill
        if (any_dis || STANDSTILL) begin
          s_nxt.st = ST_OFF;                                          // R07
        end
      end
      ST_OFF: begin
        // restart once no stopping alarm is left
        if (!(any_dis || any_fast || any_norm || any_tlim)) begin
          s_nxt.st = ST_RUN;                                          // R12 R14
        end
      end
      default: begin
        s_nxt.st = ST_OFF;
      end
    endcase

    //----------------------------------------------------------------------
    // outputs, all taken from next state so they leave a flop
    s_nxt.cmd.enable      = (s_nxt.st != ST_OFF);
    s_nxt.cmd.fast_stop   = (s_nxt.st == ST_FAST);
    s_nxt.cmd.normal_stop = (s_nxt.st == ST_NORM);
    s_nxt.cmd.tlim_stop   = (s_nxt.st == ST_TLIM);
    s_nxt.warn            = |eff;                                     // R03
    s_nxt.relay_ok        = ~|(eff & s_nxt.relay_en);                 // R09
    s_nxt.mo_out          = act[1];                                   // R12 R13
  end

  //////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_r          <= '0;
      s_r.st       <= ST_RUN;
      s_r.cmd      <= 4'h8;       // drive enabled, no stop
      s_r.relay_ok <= 1'b1;       // relay closed, drive ok
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ports straight from flops

  assign APB_RSP            = s_r.rsp;
  assign DRIVE_CMD          = s_r.cmd;
  assign ALARM_WARNING      = s_r.warn;
  assign DRIVE_OK_RELAY     = s_r.relay_ok;
  assign MOTOR_OVERLOAD_OUT = s_r.mo_out;
  assign IRQ                = s_r.irq;

endmodule
`default_nettype wire

// >>> verif/alarm_reaction_asserts.sv
/*
  Checker for the alarm reaction block, bound to its top module.
  Assumes one clock domain and a synchronous active-high reset.
*/
`default_nettype none
module alarm_reaction_asserts (
  // clock and reset
  input wire logic                  REF_CLK,
  input wire logic                  SYS_RST,
  // causes
  input wire logic [15:0]           MOTOR_HEAT,
  input wire logic                  FAST_RAMP_DONE,
  input wire logic                  NORMAL_RAMP_DONE,
  input wire logic                  STANDSTILL,
  // effects
  input wire alarm_pkg::drive_cmd_t DRIVE_CMD,
  input wire logic                  ALARM_WARNING,
  input wire logic                  DRIVE_OK_RELAY,
  input wire logic                  MOTOR_OVERLOAD_OUT,
  input wire logic                  IRQ
);
  import alarm_pkg::*;
  // one clock; reset silences every check
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  //////////////////////////////////////////////////////////////////////////////
  // at most one kind of stop is commanded
  chk_stop_onehot: assert property (
    $onehot0({DRIVE_CMD.fast_stop, DRIVE_CMD.normal_stop, DRIVE_CMD.tlim_stop}))
    else $error("more than one stop command");
  // an opened relay always comes with a flagged alarm
  chk_relay_warn: assert property (!DRIVE_OK_RELAY |-> ALARM_WARNING)
    else $error("relay open without alarm");
  // full motor accumulator shows on the output one edge later
  chk_heat_full: assert property (MOTOR_HEAT == 16'hFFFF |=> MOTOR_OVERLOAD_OUT)
    else $error("motor overload output missed");
  // output stays while any heat remains, latch or not
  chk_heat_hold: assert property (
    MOTOR_OVERLOAD_OUT && MOTOR_HEAT != 16'h0000 |=> MOTOR_OVERLOAD_OUT)
    else $error("motor overload output dropped early");
  // finished fast ramp ends in a disabled drive
  chk_fast_done: assert property (
    DRIVE_CMD.fast_stop && FAST_RAMP_DONE |=> !DRIVE_CMD.enable && !DRIVE_CMD.fast_stop)
    else $error("fast ramp did not disable");
  // a fast ramp is only ever left towards the off state
  chk_fast_fell: assert property ($fell(DRIVE_CMD.fast_stop) |-> !DRIVE_CMD.enable)
    else $error("fast ramp abandoned");
  // normal ramp ends off, unless a stronger stop took over
  chk_norm_done: assert property (DRIVE_CMD.normal_stop && NORMAL_RAMP_DONE |=>
    !DRIVE_CMD.normal_stop && (!DRIVE_CMD.enable || DRIVE_CMD.fast_stop || DRIVE_CMD.tlim_stop))
    else $error("normal ramp did not end");
  // torque stop disables at standstill
  chk_tlim_stop: assert property (DRIVE_CMD.tlim_stop && STANDSTILL |=> !DRIVE_CMD.enable)
    else $error("torque stop did not disable");
  // main scenarios reached
  cover property (DRIVE_CMD.fast_stop && FAST_RAMP_DONE);
  cover property (DRIVE_CMD.tlim_stop && STANDSTILL);
  cover property (!DRIVE_OK_RELAY && IRQ);
endmodule
bind alarm_reaction alarm_reaction_asserts chk_inst (.*);
`default_nettype wire

// >>> verif/alarm_far_side.sv
/*
  Far side model: brake feedback and the two operator reset lines.
  Assumes the bench changes its requests just after a rising edge.
*/
`default_nettype none
module alarm_far_side (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic brake_cmd,
  input wire logic fb_stuck,   // feedback refuses to follow
  input wire logic fb_slow,    // feedback lags the command
  input wire logic key_req,
  input wire logic din_req,
  // lines into the block
  output logic     brake_fb,
  output logic     keypad_rst,
  output logic     din_rst
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] lag_r;  // brake travel delay line
  // a real brake needs time to move, so a slow one shows a brief mismatch
  always_ff @(posedge clk) lag_r <= {lag_r[1:0], brake_cmd};
  assign brake_fb = fb_stuck ^ (fb_slow ? lag_r[2] : brake_cmd);
  // operator reset buttons: high while pressed, low when released
  always_ff @(posedge clk) begin
    keypad_rst <= key_req;
    din_rst    <= din_req;
  end
endmodule
`default_nettype wire

// >>> verif/test_brake_and_overload_alarm_reaction.sv
/*
  Self-checking bench for the alarm reaction block with its far side model.
  Assumes the checker is bound to the design by its own file.
*/
`include "alarm_defines.svh"
`default_nettype none
module test_brake_and_overload_alarm_reaction;
  timeunit 1ns;
  timeprecision 100ps;
  import alarm_pkg::*;
  logic        ref_clk = 0, sys_rst = 1;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  drive_cmd_t  cmd;
  logic        brake_cmd = 0, stuck = 0, slow = 0, key_req = 0, din_req = 0;
  logic        brake_fb, keypad_rst, din_rst, warn, relay, mo_out, irq;
  logic [15:0] mheat = '0, dheat = '0;
  logic        fdone = 0, ndone = 0, still = 0, en;
  logic [32:0] q;         // last bus answer: error flag and data
  logic [7:0]  expv;      // expected outputs
  int          fail_count = 0, num_checks = 0, a, s;
  // row table: drive command per selector code
  localparam logic [3:0] STOPS [6] = '{4'h8, 4'h8, 4'h0, 4'hC, 4'hA, 4'h9};
  always #12.5 ref_clk = ~ref_clk;
  alarm_reaction dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .APB_REQ(req), .APB_RSP(rsp),
    .BRAKE_CMD(brake_cmd), .BRAKE_FB(brake_fb), .KEYPAD_RST(keypad_rst),
    .DIN_ALARM_RST(din_rst), .MOTOR_HEAT(mheat), .DRIVE_HEAT(dheat), .FAST_RAMP_DONE(fdone),
    .NORMAL_RAMP_DONE(ndone), .STANDSTILL(still), .DRIVE_CMD(cmd), .ALARM_WARNING(warn),
    .DRIVE_OK_RELAY(relay), .MOTOR_OVERLOAD_OUT(mo_out), .IRQ(irq));
  alarm_far_side far (.clk(ref_clk), .brake_cmd(brake_cmd), .fb_stuck(stuck), .fb_slow(slow),
    .key_req(key_req), .din_req(din_req), .brake_fb(brake_fb), .keypad_rst(keypad_rst),
    .din_rst(din_rst));
  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; an idle edge follows so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    req.paddr <= ad;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // look at the settled answer mid-cycle; the next rising edge completes
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk);
      if (rsp.pready === 1'b1) break;
      @(posedge ref_clk);
    end
    if (rsp.pready !== 1'b1) fail_count++;
    q = {rsp.pslverr, rsp.prdata};
    @(posedge ref_clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // set or clear the cause of one alarm: 0 brake, 1 motor, 2 drive
  task automatic raise(input int k, input logic on);
    case (k)
      0: stuck <= on;
      1: mheat <= on ? 16'hFFFF : 16'h0000;
      default: dheat <= on ? 16'hFFFF : 16'h0000;
    endcase
  endtask
  function automatic logic [7:0] obs();
    return {cmd, warn, relay, mo_out, irq};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the fewer than a thousand cycles needed
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("reset outputs", 8'h84, obs());
    apb(1'b0, 8'h10, '0);
    chk("unmapped read", 33'h1_0000_0000, q);
    // every selector on every alarm, relay enable alternating
    for (a = 0; a < 3; a++) for (s = 0; s < 6; s++) begin
      en = a[0] ^ s[0];
      apb(1'b1, `CTRL_OFF, (s << (3 * a)) | (32'(en) << (9 + a)));
      apb(1'b1, `MASK_OFF, 32'h7);
      raise(a, 1'b1);
      repeat (5) @(posedge ref_clk);
      expv = {STOPS[s], s != 0, !(s != 0 && en), a == 1, s != 0};
      chk("reaction", expv, obs());
      apb(1'b0, `STATUS_OFF, '0);
      chk("status", 33'(s != 0) << a, q);
      raise(a, 1'b0);
      {fdone, ndone, still} <= 3'b111;
      repeat (6) @(posedge ref_clk);
      chk("released", {7'h42, s != 0}, obs());
      apb(1'b1, `STATUS_OFF, 32'h7);
      {fdone, ndone, still} <= 3'b000;
      chk("irq cleared", 1'b0, irq);
    end
    // latched motor overload released by keypad, then by digital input
    apb(1'b1, `CTRL_OFF, 32'h1008);
    apb(1'b1, `MASK_OFF, 32'h0);
    for (a = 0; a < 2; a++) begin
      raise(1, 1'b1);
      repeat (3) @(posedge ref_clk);
      raise(1, 1'b0);
      repeat (6) @(posedge ref_clk);
      chk("latched", 2'b10, {mo_out, irq});
      if (a == 0) key_req <= 1'b1;
      else din_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      {key_req, din_req} <= 2'b00;
      repeat (4) @(posedge ref_clk);
      chk("operator release", 1'b0, mo_out);
    end
    // normal stop on brake overtaken by fast stop on drive
    apb(1'b1, `CTRL_OFF, 32'hC4);
    raise(0, 1'b1);
    repeat (5) @(posedge ref_clk);
    chk("normal ramp", 4'hA, cmd);
    raise(2, 1'b1);
    repeat (2) @(posedge ref_clk);
    chk("fast takeover", 4'hC, cmd);
    raise(0, 1'b0);
    raise(2, 1'b0);
    fdone <= 1'b1;
    repeat (6) @(posedge ref_clk);
    fdone <= 1'b0;
    // slow brake: a moving brake mismatches briefly
    apb(1'b1, `CTRL_OFF, 32'h1);
    apb(1'b1, `STATUS_OFF, 32'h7);
    slow <= 1'b1;
    brake_cmd <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, `STATUS_OFF, '0);
    chk("brake lag event", 33'h1, q);
    chk("brake settled", 1'b0, warn);
    // second reset in mid-alarm returns all outputs to idle
    apb(1'b1, `CTRL_OFF, 32'h1C0);
    raise(2, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk("code 7 disables", 1'b0, cmd.enable);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("mid-run reset", 8'h84, obs());
    wrap_up();
  end
endmodule
`default_nettype wire
